/* inc/irq_ctrl_pkg.sv */
// Purpose: constants for the vectored interrupt controller
// Assumes: AHB-Lite word registers, 200 MHz hclk
// Notes:   printed offsets F9 and FA are not word multiples, so they are indices
// Functional notes
// - Request zero comes from pin a edges as selected; vector bytes 0,1.
// - Request one comes only from falling edges of pin b; vector bytes 2,3.
// - Request two comes from timer input pin edges as selected; bytes 4,5.
// - Wide timer is request three, narrow timer four, low voltage five.
// - Simultaneous pending requests are resolved by a programmable priority encoder.
// - Priority register sits at index F9 and is write only.
// - A grant starts a cycle that disables interrupts and saves PC and flags.
// - The cycle fetches the vector byte and next byte as a 16-bit address.
// - Masked requests still latch; software polls the request register.
// - Comparator one feeds request two; comparator two feeds request zero.
// - Request register bits 7 and 6 select edges of requests two and zero.
// - Edge code 00 F/F, 01 F/R, 10 R/F, 11 both/both for two/zero.
// - Software can read the level of each edge-triggered request, comparators only as ANDed into zero and two.
package irq_ctrl_pkg;
    localparam int          NUM_REQ        = 6;
    localparam logic [7:0]  IDX_PRIORITY   = 8'hF9;
    localparam logic [7:0]  IDX_REQUEST    = 8'hFA;
    localparam logic [7:0]  IDX_MASK       = 8'hFB;
    localparam logic [7:0]  IDX_PIN_LEVEL  = 8'hFC;
    localparam logic [7:0]  IDX_STATUS     = 8'hFD;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'hFE;
    localparam logic [7:0]  IDX_VECTOR     = 8'hFF;
    localparam int          EDGE_SEL_TWO   = 7;
    localparam int          EDGE_SEL_ZERO  = 6;
    localparam logic [7:0]  PRIORITY_RESET = 8'h00;
    localparam logic [7:0]  REQUEST_RESET  = 8'h00;
    localparam logic [5:0]  MASK_RESET     = 6'h00;
    localparam logic [1:0]  STAT_GRANT     = 2'h0;
    localparam logic [1:0]  STAT_POLL      = 2'h1;
    localparam int          NUM_STAT       = 2;
    localparam logic [7:0]  VEC_STEP       = 8'h02;
endpackage

/* inc/vec_fetch_if.sv */
`timescale 1ns/1ps
// Purpose: carries grant and vector fetch between the controller and its fetcher
// Assumes: single clock
// Notes:   start is a one-cycle pulse
interface vec_fetch_if;
    logic        start;
    logic [7:0]  vec_addr;
    logic        busy;
    logic        done;
    logic [15:0] handler;
    modport ctrl  (output start, output vec_addr, input busy, input done, input handler);
    modport fetch (input start, input vec_addr, output busy, output done, output handler);
endinterface

/* src/vec_fetch.sv */
`timescale 1ns/1ps
// Purpose: interrupt machine cycle: save context, fetch two vector bytes
// Assumes: program memory answers one cycle after pm_rd
// Notes:   high byte is at the vector location, low byte at the next one
module vec_fetch
    import irq_ctrl_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    vec_fetch_if.fetch vf,
    output logic       save_ctx,
    output logic       pm_rd,
    output logic [15:0] pm_addr,
    input  wire logic [7:0] pm_data
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HI   = 4'b0010,
        ST_LO   = 4'b0100,
        ST_DONE = 4'b1000
    } fetch_state_t;

    fetch_state_t state_q;
    logic [7:0]   addr_q;
    logic [15:0]  handler_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            addr_q  <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (vf.start)
                    begin
                        state_q <= ST_HI;
                        addr_q  <= vf.vec_addr;
                    end
                end
                ST_HI:   state_q <= ST_LO;
                ST_LO:   state_q <= ST_DONE;
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            handler_q <= 16'h0000;
        else if (state_q == ST_LO)
            handler_q[15:8] <= pm_data;
        else if (state_q == ST_DONE)
            handler_q[7:0] <= pm_data;
    end

    assign save_ctx   = (state_q == ST_HI);
    assign pm_rd      = (state_q == ST_HI) || (state_q == ST_LO);
    assign pm_addr    = {8'h00, (state_q == ST_LO) ? addr_q + 8'h01 : addr_q};
    assign vf.busy    = (state_q != ST_IDLE);
    assign vf.done    = (state_q == ST_DONE);
    assign vf.handler = {handler_q[15:8], (state_q == ST_DONE) ? pm_data : handler_q[7:0]};

    // Fetch covers two consecutive bytes
    fetch_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_HI) |=> pm_rd && pm_addr[7:0] == $past(addr_q) + 8'h01)
        else $error("second vector byte not fetched");
endmodule

/* src/irq_ctrl.sv */
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
// Purpose: six-source vectored interrupt controller with AHB-Lite registers
// Assumes: pins asynchronous, timers and detector on hclk
// Notes:   one request serviced at a time; ie_set re-enables after the handler
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        edge_pin_a,
    input  wire logic        edge_pin_b,
    input  wire logic        timer_input_pin,
    input  wire logic        comparator_one,
    input  wire logic        comparator_two,
    input  wire logic        wide_timer,
    input  wire logic        narrow_timer,
    input  wire logic        low_voltage_detect,
    input  wire logic        ie_set,
    output logic             int_enabled,
    output logic             save_ctx,
    output logic             pm_rd,
    output logic      [15:0] pm_addr,
    input  wire logic [7:0]  pm_data,
    output logic             branch,
    output logic      [15:0] handler_addr,
    output logic             irq
);
    vec_fetch_if vf();

    logic [4:0]  sync1_q;
    logic [4:0]  sync2_q;
    logic [4:0]  prev_q;
    logic [7:0]  priority_q;
    logic [7:0]  request_q;
    logic [5:0]  req_q;
    logic [1:0]  edge_sel_q;
    logic [5:0]  mask_q;
    logic [NUM_STAT-1:0] status_q;
    logic [NUM_STAT-1:0] irq_mask_q;
    logic        ie_q;
    logic [5:0]  set_req;
    logic        src_a;
    logic        src_b;
    logic        src_t;
    logic        rise_a;
    logic        fall_a;
    logic        rise_t;
    logic        fall_t;
    logic        fall_b;
    logic [5:0]  pend;
    logic [2:0]  grant_idx;
    logic        grant;
    logic [5:0]  grant_clr;
    logic [7:0]  vec_q;
    logic [15:0] handler_q;
    logic        branch_q;
    logic        ap_valid;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic [7:0]  ap_idx;
    logic        wr_en;
    logic [7:0]  wd;
    logic [7:0]  rd_d;
    logic [31:0] hrdata_q;

    // Pins pass two flops; bit order pin_a, pin_b, tin, cmp1, cmp2
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            prev_q  <= 5'h1F;
        end
        else
        begin
            sync1_q <= {comparator_two, comparator_one, timer_input_pin, edge_pin_b, edge_pin_a};
            sync2_q <= sync1_q;
            prev_q  <= {sync2_q[4], sync2_q[3], src_t, sync2_q[1], src_a};
        end
    end

    // comparators merged into requests two and zero
    assign src_a  = sync2_q[0] & sync2_q[4];
    assign src_t  = sync2_q[2] & sync2_q[3];
    assign src_b  = sync2_q[1];
    assign rise_a = src_a & ~prev_q[0];
    assign fall_a = ~src_a & prev_q[0];
    assign rise_t = src_t & ~prev_q[2];
    assign fall_t = ~src_t & prev_q[2];
    assign fall_b = ~src_b & prev_q[1];

    // Each request latch and the edge select bits have their own driver
    assign request_q = {edge_sel_q, req_q};

    always_comb
    begin
        set_req = 6'h00;
        case (request_q[EDGE_SEL_TWO:EDGE_SEL_ZERO])
            2'b00:
            begin
                set_req[0] = fall_a;
                set_req[2] = fall_t;
            end
            2'b01:
            begin
                set_req[0] = rise_a;
                set_req[2] = fall_t;
            end
            2'b10:
            begin
                set_req[0] = fall_a;
                set_req[2] = rise_t;
            end
            default:
            begin
                set_req[0] = rise_a | fall_a;
                set_req[2] = rise_t | fall_t;
            end
        endcase
        set_req[1] = fall_b;
        set_req[3] = wide_timer;
        set_req[4] = narrow_timer;
        set_req[5] = low_voltage_detect;
    end

    // AHB-Lite slave: writes land one cycle after the address phase
    assign ap_valid  = hsel && hready && htrans[1];
    assign ap_idx    = haddr[9:2];
    assign wr_en     = wr_pend_q;
    assign wd        = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end
        else
        begin
            wr_pend_q <= ap_valid && hwrite;
            wr_idx_q  <= ap_idx;
        end
    end

    // priority is write only; pin levels readable
    always_comb
    begin
        case (ap_idx)
            IDX_REQUEST:   rd_d = request_q;
            IDX_MASK:      rd_d = {2'b00, mask_q};
            IDX_PIN_LEVEL: rd_d = {5'b00000, src_t, src_b, src_a};
            IDX_STATUS:    rd_d = {6'h00, status_q};
            IDX_IRQ_MASK:  rd_d = {6'h00, irq_mask_q};
            IDX_VECTOR:    rd_d = vec_q;
            default:       rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (ap_valid && !hwrite)
            hrdata_q <= {24'h000000, rd_d};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            priority_q <= PRIORITY_RESET;
        else if (wr_en && wr_idx_q == IDX_PRIORITY)
            priority_q <= wd;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_q <= MASK_RESET;
        else if (wr_en && wr_idx_q == IDX_MASK)
            mask_q <= wd[5:0];
    end

    // latch regardless of mask; set beats clear
    generate
        for (genvar i = 0; i < NUM_REQ; i++)
        begin : g_req
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    req_q[i] <= 1'b0;
                else if (set_req[i])
                    req_q[i] <= 1'b1;
                else if (grant_clr[i])
                    req_q[i] <= 1'b0;
                else if (wr_en && wr_idx_q == IDX_REQUEST)
                    req_q[i] <= wd[i];
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            edge_sel_q <= REQUEST_RESET[7:6];
        else if (wr_en && wr_idx_q == IDX_REQUEST)
            edge_sel_q <= wd[7:6];
    end

    // priority encoder: rotate start by priority_q[2:0], request priority_q[2:0] mod 6 first
    assign pend = request_q[5:0] & mask_q;
    always_comb
    begin
        logic [2:0] k;
        logic       found;
        k         = 3'd0;
        found     = 1'b0;
        grant_idx = 3'd0;
        for (int n = 0; n < NUM_REQ; n++)
        begin
            k = 3'((32'(priority_q[2:0]) + n) % NUM_REQ);
            if (!found && pend[k])
            begin
                grant_idx = k;
                found     = 1'b1;
            end
        end
    end

    assign grant     = ie_q && (pend != 6'h00) && !vf.busy;
    assign grant_clr = grant ? 6'(6'h01 << grant_idx) : 6'h00;
    assign vf.start  = grant;
    assign vf.vec_addr = 8'(grant_idx) * VEC_STEP;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ie_q <= 1'b1;
        else if (grant)
            ie_q <= 1'b0;
        else if (ie_set && !vf.busy)
            ie_q <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vec_q     <= 8'h00;
            handler_q <= 16'h0000;
            branch_q  <= 1'b0;
        end
        else
        begin
            if (grant)
                vec_q <= vf.vec_addr;
            if (vf.done)
                handler_q <= vf.handler;
            branch_q <= vf.done;
        end
    end

    vec_fetch u_fetch (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .vf       (vf),
        .save_ctx (save_ctx),
        .pm_rd    (pm_rd),
        .pm_addr  (pm_addr),
        .pm_data  (pm_data)
    );

    // Sticky events: grant and polled-only pending, write one to clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_q <= '0;
        else
        begin
            for (int s = 0; s < NUM_STAT; s++)
            begin
                if ((s == STAT_GRANT && grant) || (s == STAT_POLL && |(set_req & ~mask_q)))
                    status_q[s] <= 1'b1;
                else if (wr_en && wr_idx_q == IDX_STATUS && wd[s])
                    status_q[s] <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_mask_q <= '0;
        else if (wr_en && wr_idx_q == IDX_IRQ_MASK)
            irq_mask_q <= wd[NUM_STAT-1:0];
    end

    assign irq          = |(status_q & irq_mask_q);
    assign int_enabled  = ie_q;
    assign branch       = branch_q;
    assign handler_addr = handler_q;

    // Grant clears the latch and disables interrupts
    grant_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
        grant && !set_req[grant_idx] |=> !request_q[$past(grant_idx)] && !ie_q)
        else $error("grant did not clear request");
    // context saved one cycle after grant
    grant_save_a: assert property (@(posedge hclk) disable iff (!hresetn)
        grant |=> save_ctx ##3 branch)
        else $error("interrupt cycle sequence wrong");
    // vector address is twice the source
    vector_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        grant |-> vf.vec_addr == {4'h0, grant_idx, 1'b0})
        else $error("wrong vector location");
    pin_b_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(src_b) && !request_q[1] |=> !request_q[1])
        else $error("rising edge set request one");
    masked_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
        set_req[4] && !mask_q[4] |=> request_q[4])
        else $error("masked request not latched");
    enc_masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
        grant |-> mask_q[grant_idx] && request_q[grant_idx])
        else $error("grant of idle request");
    both_edges_a: assert property (@(posedge hclk) disable iff (!hresetn)
        request_q[7:6] == 2'b11 && (rise_a || fall_a) |=> request_q[0])
        else $error("edge on request zero missed");
    lvd_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        low_voltage_detect |=> request_q[5])
        else $error("low voltage request lost");
endmodule

/* tb/prog_mem_model.sv */
// Purpose: program memory that holds the interrupt vector table
// Assumes: byte wide, read data one cycle after pm_rd
// Notes:   contents are a fixed pattern of the address
`timescale 1ns/1ps
module prog_mem_model
(
    input  wire logic        hclk,
    input  wire logic        pm_rd,
    input  wire logic [15:0] pm_addr,
    output logic      [7:0]  pm_data
);
    initial pm_data = 8'h00;

    always @(posedge hclk)
    begin
        if (pm_rd)
            pm_data <= pm_addr[7:0] ^ pm_addr[15:8] ^ 8'hA5;
        else
            pm_data <= ~pm_data;  // Released bus inverts the last byte every cycle
    end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: AHB-Lite single word transfers, pins idle high
// Notes:   vector table pattern must match the program memory model
`timescale 1ns/1ps
module tb_top;
    import irq_ctrl_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [4:0]  pins;
    logic [2:0]  evt;
    logic        ie_set;
    logic        int_enabled;
    logic        save_ctx;
    logic        pm_rd;
    logic [15:0] pm_addr;
    logic [7:0]  pm_data;
    logic        branch;
    logic [15:0] handler_addr;
    logic        irq;
    int          miscompares;
    int          checks_done;
    logic [1:0]  cd;

    irq_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .edge_pin_a(pins[0]), .edge_pin_b(pins[1]),
        .timer_input_pin(pins[2]), .comparator_two(pins[3]), .comparator_one(pins[4]),
        .wide_timer(evt[0]), .narrow_timer(evt[1]), .low_voltage_detect(evt[2]), .ie_set(ie_set),
        .int_enabled(int_enabled), .save_ctx(save_ctx), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pm_data(pm_data), .branch(branch), .handler_addr(handler_addr), .irq(irq));

    prog_mem_model u_mem (.hclk(hclk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_bit(input string nm, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] unused;
        bus(1'b1, idx, wd, unused);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        check_val(nm, {24'h0, exp}, {24'h0, rd});
    endtask

    task automatic set_pins(input logic [4:0] v, input int settle);
        @(posedge hclk);
        pins <= v;
        repeat (settle) @(posedge hclk);
    endtask

    task automatic pulse_ie;
        @(posedge hclk);
        ie_set <= 1'b1;
        @(posedge hclk);
        ie_set <= 1'b0;
    endtask

    task automatic expect_grant(input int k);
        logic [7:0] va;
        va = 8'(2 * k);
        do @(posedge hclk); while (save_ctx !== 1'b1);
        check_bit("vector read", 1'b1, pm_rd);
        check_val("vector address", {24'h0, va}, {16'h0, pm_addr});
        check_bit("interrupts disabled", 1'b0, int_enabled);
        repeat (3) @(posedge hclk);
        check_bit("branch", 1'b1, branch);
        check_val("handler", {16'h0, va ^ 8'hA5, (va + 8'h01) ^ 8'hA5}, {16'h0, handler_addr});
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        conclude();
    end

    initial
    begin
        miscompares = 0;
        checks_done = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pins = 5'h1F;
        evt = 3'h0;
        ie_set = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_bit("enable after reset", 1'b1, int_enabled);
        check_bit("irq after reset", 1'b0, irq);
        check_bit("hreadyout", 1'b1, hreadyout);
        check_bit("hresp", 1'b0, hresp);
        rd_chk("request reset", IDX_REQUEST, REQUEST_RESET);
        rd_chk("mask reset", IDX_MASK, 8'h00);
        wr_reg(8'h10, 8'h5A);
        rd_chk("unmapped", 8'h10, 8'h00);
        wr_reg(IDX_PRIORITY, 8'h03);
        rd_chk("priority readback", IDX_PRIORITY, 8'h00);
        wr_reg(IDX_IRQ_MASK, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            cd = 2'(c);
            wr_reg(IDX_REQUEST, {cd, 6'h00});
            set_pins(5'h18, 8);
            rd_chk("falling edges", IDX_REQUEST, {cd, 3'b000, cd != 2'd2, 1'b1, cd != 2'd1});
            wr_reg(IDX_REQUEST, {cd, 6'h00});
            set_pins(5'h1F, 8);
            rd_chk("rising edges", IDX_REQUEST, {cd, 3'b000, cd[1], 1'b0, cd[0]});
        end
        check_bit("masked irq", 1'b0, irq);
        wr_reg(IDX_REQUEST, 8'h00);
        rd_chk("pin levels high", IDX_PIN_LEVEL, 8'h07);
        set_pins(5'h17, 8);
        rd_chk("pin levels cmp two", IDX_PIN_LEVEL, 8'h06);
        rd_chk("comparator two request", IDX_REQUEST, 8'h01);
        set_pins(5'h07, 8);
        rd_chk("pin levels", IDX_PIN_LEVEL, 8'h02);
        rd_chk("comparator requests", IDX_REQUEST, 8'h05);
        set_pins(5'h1F, 8);
        wr_reg(IDX_REQUEST, 8'h00);
        @(posedge hclk);
        evt <= 3'h7;
        @(posedge hclk);
        evt <= 3'h0;
        rd_chk("internal requests", IDX_REQUEST, 8'h38);
        rd_chk("status", IDX_STATUS, 8'h02);
        wr_reg(IDX_PRIORITY, 8'h04);
        wr_reg(IDX_MASK, 8'h3F);
        expect_grant(4);
        check_bit("irq raised", 1'b1, irq);
        rd_chk("after grant", IDX_REQUEST, 8'h28);
        wr_reg(IDX_STATUS, 8'h03);
        @(posedge hclk);
        check_bit("irq cleared", 1'b0, irq);
        wr_reg(IDX_PRIORITY, 8'h00);
        pulse_ie();
        expect_grant(3);
        pulse_ie();
        expect_grant(5);
        pulse_ie();
        for (int k = 0; k < 3; k++)
        begin
            set_pins(5'h1F & ~(5'h01 << k), 0);
            expect_grant(k);
            pulse_ie();
            set_pins(5'h1F, 8);
        end
        rd_chk("all serviced", IDX_REQUEST, 8'h00);
        conclude();
    end
endmodule
